// [rtl/mpt_cfg.svh]
`ifndef MPT_CFG_SVH
`define MPT_CFG_SVH

// register offsets, byte addresses
`define MPT_CTRL 8'h00
`define MPT_PRESC 8'h04
`define MPT_RELOAD 8'h08
`define MPT_COUNT 8'h0C
`define MPT_STATUS 8'h10
`define MPT_MASK 8'h14
`define MPT_DEADT 8'h18
`define MPT_CHMODE 8'h1C
`define MPT_DMAEN 8'h20
`define MPT_CMP0 8'h30
`define MPT_CMP_PAGE 4'h3

// control fields
`define MPT_C_EN 0
`define MPT_C_MODE 2:1
`define MPT_C_ONEP 3
`define MPT_C_FRZ 4
`define MPT_C_ENC 5
`define MPT_C_HALL 6
`define MPT_C_MOE 7
`define MPT_C_SLV 9:8

// status, mask and dma-enable bits
`define MPT_S_UPD 0
`define MPT_S_HALL 5
`define MPT_NEV 6

// reset values and widths
`define MPT_RELOAD_RST 32'h0000_FFFF
`define MPT_DT_W 8

`endif

// [rtl/mpt_pkg.sv]
`default_nettype none
package mpt_pkg;

  typedef enum logic [1:0] {CNT_UP, CNT_DOWN, CNT_CENTER} mpt_cnt_mode_t;

  typedef enum logic [2:0] {
    CH_OFF, CH_CAP_RISE, CH_CAP_FALL, CH_CMP_TOGGLE,
    CH_PWM, CH_PWM_INV, CH_FORCE_LO, CH_FORCE_HI
  } mpt_ch_mode_t;

  typedef enum logic [1:0] {SLV_FREE, SLV_RESET, SLV_GATED, SLV_START} mpt_slave_t;

  typedef struct packed {
    logic en, onep, frz, enc, hall, moe, down, dma_req, trgo, irq;
    mpt_cnt_mode_t mode;
    mpt_slave_t slave;
    logic [15:0] presc;
    logic [15:0] psc_cnt;
    logic [31:0] reload;
    logic [31:0] cnt;
    logic [3:0][31:0] cmp;
    mpt_ch_mode_t [3:0] chm;
    logic [5:0] sts;
    logic [5:0] mask;
    logic [5:0] dmaen;
    logic [7:0] dt;
    logic [3:0] s1, s2, s3, filt, filt_q, ch_out, ch_oe;
    logic [31:0] rdata;
  } mpt_state_t;

  typedef struct packed {
    logic ref_q, main, comp;
    logic [7:0] cnt;
  } mpt_dt_state_t;

endpackage : mpt_pkg
`default_nettype wire

// [rtl/mpt_dead_time.sv]
`timescale 1ns/1ps
`default_nettype none
module mpt_dead_time
  import mpt_pkg::*;
(
  // clock and reset
  input wire logic i_clock,
  input wire logic i_nrst,
  // reference and setting
  input wire logic i_en,
  input wire logic i_ref,
  input wire logic [7:0] i_dt,
  // pair outputs
  output logic o_main,
  output logic o_comp
);

  mpt_dt_state_t st_ff, nxt_st;

  always_comb begin
    nxt_st = st_ff;
    if (!i_en) begin
      nxt_st.ref_q = i_ref;
      nxt_st.main = 1'b0;
      nxt_st.comp = 1'b0;
      nxt_st.cnt = 8'h00;
    end else if (i_ref != st_ff.ref_q) begin
      // both off first when i_dt is nonzero, active side waits the dead time
      nxt_st.ref_q = i_ref;
      nxt_st.main = (i_dt == 8'h00) & i_ref; // R19
      nxt_st.comp = (i_dt == 8'h00) & ~i_ref; // R19
      nxt_st.cnt = i_dt;
    end else if (st_ff.cnt != 8'h00) begin
      nxt_st.cnt = st_ff.cnt - 8'h01;
      nxt_st.main = (st_ff.cnt == 8'h01) & st_ff.ref_q; // R6
      nxt_st.comp = (st_ff.cnt == 8'h01) & ~st_ff.ref_q; // R6
    end else begin
      nxt_st.main = st_ff.ref_q;
      nxt_st.comp = ~st_ff.ref_q;
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_main = st_ff.main;
  assign o_comp = st_ff.comp;

  ////////////////////////////////////////////////////////////////////////////
  a_pair_no_overlap: assert property ( // R6
    @(posedge i_clock) disable iff (!i_nrst) !(o_main && o_comp))
    else $error("main and complementary both active");

  a_dt_rise_delay: assert property ( // R19
    @(posedge i_clock) disable iff (!i_nrst)
    i_en && i_ref && !st_ff.ref_q && i_dt == 8'h03 ##1 i_en && i_ref ##1 i_en && i_ref
    ##1 i_en && i_ref |-> !o_main ##1 o_main)
    else $error("active edge not delayed by dead time");

endmodule : mpt_dead_time
`default_nettype wire

// [rtl/mpt_timer.sv]
// Function
// R1: prescaler divides by any integer from 1 to 65536.
// R2: counter counts up, down, or up then down (center-aligned).
// R3: wide instance uses a 32-bit auto-reload counter with 16-bit prescaler.
// R4: other instances use a 16-bit auto-reload counter with 16-bit prescaler.
// R5: motor-control instance drives three-phase PWM on six lines via pairs.
// R6: dead time keeps main and complementary outputs from being active together.
// R7: channels do capture, compare, edge or center PWM, one-period output.
// R8: PWM duty spans constantly inactive to constantly active.
// R9: debug halt may freeze counter and force PWM outputs off.
// R10: general timers may freeze counter during debug halt.
// R11: link input and output let timers synchronise or chain.
// R12: full general timers offer up to four capture/compare channels.
// R13: full general timers accept quadrature encoder and three hall sensors.
// R14: each timer raises its own DMA request.
// R15: mid-size variant has two channels plus two complementary channels.
// R16: small variant has one channel plus one complementary channel.
// R17: basic variant is an up-only 16-bit time base driving converter triggers; code still counts down in encoder mode (enc set).
// R18: update event and reload on overflow up and underflow down.
// R19: dead time delays each active-going edge by programmed clock cycles.
`timescale 1ns/1ps
`default_nettype none
`include "mpt_cfg.svh"
module mpt_timer
  import mpt_pkg::*;
#(
  parameter int CW = 16,
  parameter int NCH = 4,
  parameter int NCP = 3,
  parameter bit BASIC = 1'b0
) (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_nrst,
  // register port
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // channel pins
  input wire logic [NCH-1:0] i_ch_in,
  output logic [NCH-1:0] o_ch_out,
  output logic [NCH-1:0] o_ch_oe,
  output logic [NCH-1:0] o_chn_out,
  // link and debug
  input wire logic i_link_trig,
  output logic o_link_trgo,
  input wire logic i_dbg_halt,
  // dma and interrupt
  input wire logic i_dma_ack,
  output logic o_dma_req,
  output logic o_irq
);

  function automatic logic is_out(input mpt_ch_mode_t m);
    return m inside {CH_CMP_TOGGLE, CH_PWM, CH_PWM_INV, CH_FORCE_LO, CH_FORCE_HI};
  endfunction : is_out

  function automatic mpt_state_t rst_state();
    mpt_state_t s;
    s = '0;
    s.reload = `MPT_RELOAD_RST;
    return s;
  endfunction : rst_state

  mpt_state_t st_ff, nxt_st;
  logic [31:0] cmask, rld;
  logic frozen, run, tick, step;

  ////////////////////////////////////////////////////////////////////////////
  // time base enables
  assign cmask = (CW >= 32) ? 32'hFFFF_FFFF : ((32'h1 << CW) - 32'h1); // R3 R4
  assign rld = st_ff.reload & cmask;
  assign frozen = i_dbg_halt & st_ff.frz; // R9 R10
  assign run = st_ff.en & ~frozen & ((st_ff.slave != SLV_GATED) | i_link_trig); // R11
  assign tick = run & (st_ff.psc_cnt == st_ff.presc); // R1
  assign step = st_ff.enc ? (run & (st_ff.filt[0] ^ st_ff.filt_q[0])) : tick; // R13

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    logic up;
    logic [31:0] c;
    logic [5:0] ev;
    logic [31:0] ctrl_rd;
    up = 1'b1;
    c = st_ff.cnt;
    ev = '0;
    ctrl_rd = '0;
    nxt_st = st_ff;
    // three-stage pin sampling, change taken once stages two and three agree
    nxt_st.s1 = 4'(i_ch_in);
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    nxt_st.filt_q = st_ff.filt;
    for (int i = 0; i < 4; i++) begin
      if (st_ff.s2[i] == st_ff.s3[i]) begin
        nxt_st.filt[i] = st_ff.s3[i];
      end
    end
    if (run) begin
      nxt_st.psc_cnt = tick ? 16'h0000 : st_ff.psc_cnt + 16'h0001; // R1
    end
    // direction
    if (st_ff.enc) begin
      up = st_ff.filt[0] ^ st_ff.filt[1]; // R13
    end else if (!BASIC) begin
      unique case (st_ff.mode) // R2
        CNT_UP: up = 1'b1;
        CNT_DOWN: up = 1'b0;
        CNT_CENTER: up = ~st_ff.down;
        default: up = 1'b1;
      endcase
    end
    // counter, update on overflow and underflow
    if (step) begin
      if (up) begin
        if (c >= rld) begin
          ev[`MPT_S_UPD] = 1'b1; // R18
          if (st_ff.mode == CNT_CENTER && !st_ff.enc && !BASIC) begin
            nxt_st.down = 1'b1; // R2
            c = c - 32'h1;
          end else begin
            c = 32'h0; // R18
          end
        end else begin
          c = c + 32'h1;
        end
      end else begin
        if (c == 32'h0) begin
          ev[`MPT_S_UPD] = 1'b1; // R18
          if (st_ff.mode == CNT_CENTER && !st_ff.enc) begin
            nxt_st.down = 1'b0; // R2
            c = 32'h1;
          end else begin
            c = rld; // R18
          end
        end else begin
          c = c - 32'h1;
        end
      end
    end
    // one-period mode stops at the update
    if (st_ff.onep && ev[`MPT_S_UPD]) begin
      nxt_st.en = 1'b0; // R7
    end
    // hall change: capture interval into channel 0, restart count
    if (st_ff.hall && !BASIC && (st_ff.filt[2:0] != st_ff.filt_q[2:0])) begin
      ev[`MPT_S_HALL] = 1'b1; // R13
      nxt_st.cmp[0] = st_ff.cnt;
      c = 32'h0;
    end
    // link slave modes
    if (st_ff.slave == SLV_RESET && i_link_trig && st_ff.en) begin
      c = 32'h0; // R11
      nxt_st.psc_cnt = 16'h0000;
    end
    if (st_ff.slave == SLV_START && i_link_trig) begin
      nxt_st.en = 1'b1; // R11
    end
    nxt_st.cnt = c & cmask;
    // channels
    for (int i = 0; i < NCH; i++) begin
      if (!BASIC) begin // R12 R17
        unique case (st_ff.chm[i])
          CH_OFF: nxt_st.ch_out[i] = 1'b0;
          CH_CAP_RISE: begin
            if (st_ff.filt[i] && !st_ff.filt_q[i]) begin
              nxt_st.cmp[i] = st_ff.cnt; // R7
              ev[i + 1] = 1'b1;
            end
          end
          CH_CAP_FALL: begin
            if (!st_ff.filt[i] && st_ff.filt_q[i]) begin
              nxt_st.cmp[i] = st_ff.cnt; // R7
              ev[i + 1] = 1'b1;
            end
          end
          CH_CMP_TOGGLE: begin
            if (step && st_ff.cnt == (st_ff.cmp[i] & cmask)) begin
              nxt_st.ch_out[i] = ~st_ff.ch_out[i]; // R7
              ev[i + 1] = 1'b1;
            end
          end
          CH_PWM: begin
            nxt_st.ch_out[i] = st_ff.cnt < (st_ff.cmp[i] & cmask); // R8
            ev[i + 1] = step && st_ff.cnt == (st_ff.cmp[i] & cmask);
          end
          CH_PWM_INV: begin
            nxt_st.ch_out[i] = st_ff.cnt >= (st_ff.cmp[i] & cmask); // R8
            ev[i + 1] = step && st_ff.cnt == (st_ff.cmp[i] & cmask);
          end
          CH_FORCE_LO: nxt_st.ch_out[i] = 1'b0;
          CH_FORCE_HI: nxt_st.ch_out[i] = 1'b1;
        endcase
      end
      nxt_st.ch_oe[i] = st_ff.moe & ~frozen & is_out(st_ff.chm[i]) & ~BASIC;
      if (frozen || !st_ff.moe) begin
        nxt_st.ch_out[i] = 1'b0; // R9
      end
    end
    // register writes
    if (i_wr) begin
      if (i_addr == `MPT_CTRL) begin
        nxt_st.en = i_wdata[`MPT_C_EN];
        nxt_st.mode = mpt_cnt_mode_t'(i_wdata[`MPT_C_MODE]);
        nxt_st.onep = i_wdata[`MPT_C_ONEP];
        nxt_st.frz = i_wdata[`MPT_C_FRZ];
        nxt_st.enc = i_wdata[`MPT_C_ENC];
        nxt_st.hall = i_wdata[`MPT_C_HALL];
        nxt_st.moe = i_wdata[`MPT_C_MOE];
        nxt_st.slave = mpt_slave_t'(i_wdata[`MPT_C_SLV]);
      end
      if (i_addr == `MPT_PRESC) begin
        nxt_st.presc = i_wdata[15:0]; // R1
        nxt_st.psc_cnt = 16'h0000;
      end
      if (i_addr == `MPT_RELOAD) begin
        nxt_st.reload = i_wdata & cmask;
      end
      if (i_addr == `MPT_COUNT) begin
        nxt_st.cnt = i_wdata & cmask;
      end
      if (i_addr == `MPT_MASK) begin
        nxt_st.mask = i_wdata[5:0];
      end
      if (i_addr == `MPT_DMAEN) begin
        nxt_st.dmaen = i_wdata[5:0];
      end
      if (i_addr == `MPT_DEADT) begin
        nxt_st.dt = i_wdata[7:0];
      end
      if (i_addr == `MPT_CHMODE) begin
        for (int i = 0; i < 4; i++) begin
          nxt_st.chm[i] = mpt_ch_mode_t'(i_wdata[3 * i +: 3]);
        end
      end
      if (i_addr[7:4] == `MPT_CMP_PAGE) begin
        nxt_st.cmp[i_addr[3:2]] = i_wdata & cmask;
      end
    end
    // sticky status, a new event beats a clear in the same cycle
    if (i_wr && i_addr == `MPT_STATUS) begin
      nxt_st.sts = (st_ff.sts & ~i_wdata[5:0]) | ev;
    end else begin
      nxt_st.sts = st_ff.sts | ev;
    end
    if (|(ev & st_ff.dmaen)) begin
      nxt_st.dma_req = 1'b1; // R14
    end else if (i_dma_ack) begin
      nxt_st.dma_req = 1'b0;
    end
    nxt_st.trgo = ev[`MPT_S_UPD]; // R11 R17
    nxt_st.irq = |(nxt_st.sts & nxt_st.mask);
    // read data, valid only in the cycle after the strobe
    ctrl_rd[`MPT_C_EN] = st_ff.en;
    ctrl_rd[`MPT_C_MODE] = st_ff.mode;
    ctrl_rd[`MPT_C_ONEP] = st_ff.onep;
    ctrl_rd[`MPT_C_FRZ] = st_ff.frz;
    ctrl_rd[`MPT_C_ENC] = st_ff.enc;
    ctrl_rd[`MPT_C_HALL] = st_ff.hall;
    ctrl_rd[`MPT_C_MOE] = st_ff.moe;
    ctrl_rd[`MPT_C_SLV] = st_ff.slave;
    nxt_st.rdata = 32'h0;
    if (i_rd) begin
      if (i_addr[7:4] == `MPT_CMP_PAGE) begin
        nxt_st.rdata = st_ff.cmp[i_addr[3:2]];
      end else begin
        case (i_addr)
          `MPT_CTRL: nxt_st.rdata = ctrl_rd;
          `MPT_PRESC: nxt_st.rdata = {16'h0000, st_ff.presc};
          `MPT_RELOAD: nxt_st.rdata = st_ff.reload;
          `MPT_COUNT: nxt_st.rdata = st_ff.cnt;
          `MPT_STATUS: nxt_st.rdata = {26'h0, st_ff.sts};
          `MPT_MASK: nxt_st.rdata = {26'h0, st_ff.mask};
          `MPT_DEADT: nxt_st.rdata = {24'h0, st_ff.dt};
          `MPT_CHMODE: nxt_st.rdata = {20'h0, st_ff.chm};
          `MPT_DMAEN: nxt_st.rdata = {26'h0, st_ff.dmaen};
          default: nxt_st.rdata = 32'h0;
        endcase
      end
    end
  end

  always_ff @(posedge i_clock) begin
    if (!i_nrst) begin
      st_ff <= rst_state();
    end else begin
      st_ff <= nxt_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // complementary pairs: channels below NCP go through dead time
  for (genvar k = 0; k < NCH; k++) begin : g_pair
    logic dt_main;
    mpt_dead_time u_dt (
      .i_clock(i_clock),
      .i_nrst(i_nrst),
      .i_en(st_ff.ch_oe[k] && (k < NCP)), // R5 R15 R16
      .i_ref(st_ff.ch_out[k]),
      .i_dt(st_ff.dt),
      .o_main(dt_main),
      .o_comp(o_chn_out[k])
    );
    assign o_ch_out[k] = (k < NCP) ? dt_main : st_ff.ch_out[k];
    assign o_ch_oe[k] = st_ff.ch_oe[k];
  end

  assign o_rdata = st_ff.rdata;
  assign o_link_trgo = st_ff.trgo;
  assign o_dma_req = st_ff.dma_req;
  assign o_irq = st_ff.irq;

  ////////////////////////////////////////////////////////////////////////////
  a_psc_divide: assert property ( // R1
    @(posedge i_clock) disable iff (!i_nrst)
    run && !tick && !i_wr && !(st_ff.slave == SLV_RESET && i_link_trig)
    |=> st_ff.psc_cnt == $past(st_ff.psc_cnt) + 16'h0001)
    else $error("prescaler did not advance");

  a_up_reload: assert property ( // R18
    @(posedge i_clock) disable iff (!i_nrst)
    step && !st_ff.enc && !st_ff.hall && st_ff.mode == CNT_UP && st_ff.cnt >= rld
    && !i_wr && st_ff.slave != SLV_RESET
    |=> st_ff.cnt == 32'h0 && o_link_trgo)
    else $error("no wrap to zero on overflow");

  a_down_reload: assert property ( // R2
    @(posedge i_clock) disable iff (!i_nrst)
    !BASIC && step && !st_ff.enc && !st_ff.hall && st_ff.mode == CNT_DOWN
    && st_ff.cnt == 32'h0 && !i_wr && st_ff.slave != SLV_RESET
    |=> st_ff.cnt == $past(rld) && o_link_trgo)
    else $error("no reload on underflow");

  a_cnt_width: assert property ( // R3
    @(posedge i_clock) disable iff (!i_nrst) (st_ff.cnt & ~cmask) == 32'h0)
    else $error("counter exceeds its width");

  a_pwm_duty: assert property ( // R8
    @(posedge i_clock) disable iff (!i_nrst)
    !BASIC && st_ff.chm[0] == CH_PWM && st_ff.moe && !frozen && !i_wr
    |=> st_ff.ch_out[0] == ($past(st_ff.cnt) < ($past(st_ff.cmp[0]) & cmask)))
    else $error("pwm level does not follow compare");

  a_dbg_freeze: assert property ( // R10
    @(posedge i_clock) disable iff (!i_nrst)
    frozen && !i_wr && st_ff.slave == SLV_FREE && !st_ff.hall |=> $stable(st_ff.cnt))
    else $error("counter moved while frozen");

  a_dbg_outs_off: assert property ( // R9
    @(posedge i_clock) disable iff (!i_nrst)
    frozen |=> st_ff.ch_out == 4'h0 && st_ff.ch_oe == 4'h0 ##1 o_chn_out == '0)
    else $error("outputs active during debug halt");

  a_dma_req: assert property ( // R14
    @(posedge i_clock) disable iff (!i_nrst)
    o_link_trgo && $past(st_ff.dmaen[0]) |-> o_dma_req)
    else $error("update did not raise dma request");

  a_link_reset: assert property ( // R11
    @(posedge i_clock) disable iff (!i_nrst)
    st_ff.slave == SLV_RESET && st_ff.en && i_link_trig && !i_wr |=> st_ff.cnt == 32'h0)
    else $error("link trigger did not reset counter");

  a_capture_rise: assert property ( // R7
    @(posedge i_clock) disable iff (!i_nrst)
    !BASIC && st_ff.chm[0] == CH_CAP_RISE && st_ff.filt[0] && !st_ff.filt_q[0]
    && !st_ff.hall && !i_wr
    |=> st_ff.cmp[0] == $past(st_ff.cnt) && st_ff.sts[1])
    else $error("capture missed rising edge");

endmodule : mpt_timer
`default_nettype wire

// [verification/mpt_pins_model.sv]
`timescale 1ns/1ps
`default_nettype none
module mpt_pins_model (
  // clock
  input wire logic i_clock,
  // switch drive from the timer
  input wire logic [3:0] i_main,
  input wire logic [3:0] i_comp,
  // encoder and hall lines
  output logic [3:0] o_pins
);
  int overlap;
  initial begin
    o_pins = 4'h0;
    overlap = 0;
  end
  // both switches of a leg on shorts the rail
  always @(negedge i_clock) begin
    if ((i_main & i_comp) !== 4'h0) overlap++;
  end
  //////////////////////////////////////////////////
  // one step gives one edge on line a
  task automatic step(input bit up);
    @(posedge i_clock);
    if (up) o_pins[0] <= ~o_pins[0];
    else o_pins[1] <= ~o_pins[1];
    repeat (8) @(posedge i_clock);
    if (up) o_pins[1] <= ~o_pins[1];
    else o_pins[0] <= ~o_pins[0];
    repeat (8) @(posedge i_clock);
  endtask : step
  task automatic hall_flip();
    @(posedge i_clock);
    o_pins[2] <= ~o_pins[2];
    repeat (8) @(posedge i_clock);
  endtask : hall_flip
endmodule : mpt_pins_model
`default_nettype wire

// [verification/tb.sv]
`timescale 1ns/1ps
`default_nettype none
`include "mpt_cfg.svh"
module tb;
  logic i_clock = 1'b0;
  logic i_nrst = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_link_trig = 1'b0;
  logic i_dbg_halt = 1'b0;
  logic i_dma_ack = 1'b0;
  logic [3:0] ch_in, ch_out, ch_oe, chn_out;
  logic [31:0] o_rdata;
  logic o_link_trgo, o_dma_req, o_irq;
  logic [31:0] d, a;
  int fails = 0;
  int cmp_count = 0;
  always #50 i_clock = ~i_clock;
  mpt_timer uut (
    .i_clock(i_clock), .i_nrst(i_nrst), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_ch_in(ch_in),
    .o_ch_out(ch_out), .o_ch_oe(ch_oe), .o_chn_out(chn_out),
    .i_link_trig(i_link_trig), .o_link_trgo(o_link_trgo), .i_dbg_halt(i_dbg_halt),
    .i_dma_ack(i_dma_ack), .o_dma_req(o_dma_req), .o_irq(o_irq));
  mpt_pins_model pins (.i_clock(i_clock), .i_main(ch_out), .i_comp(chn_out), .o_pins(ch_in));
  //////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fails++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up
  task automatic wr(input logic [7:0] ad, input logic [31:0] v);
    @(posedge i_clock);
    i_wr <= 1'b1;
    i_addr <= ad;
    i_wdata <= v;
    @(posedge i_clock);
    i_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] ad);
    @(posedge i_clock);
    i_rd <= 1'b1;
    i_addr <= ad;
    @(posedge i_clock);
    i_rd <= 1'b0;
    @(negedge i_clock);
    d = o_rdata;
  endtask : rd
  // cycles between two update pulses
  task automatic span(output int n);
    int k;
    k = 0;
    @(negedge i_clock);
    while (o_link_trgo !== 1'b1 && k < 200) begin
      @(negedge i_clock);
      k++;
    end
    n = 0;
    do begin
      @(negedge i_clock);
      n++;
    end while (o_link_trgo !== 1'b1 && n < 200);
  endtask : span
  // high counts of pair 0 over 20 cycles
  task automatic win(output int m, output int c, output int z);
    m = 0;
    c = 0;
    z = 0;
    repeat (12) @(negedge i_clock);
    repeat (20) begin
      @(negedge i_clock);
      m += ch_out[0];
      c += chn_out[0];
      z += (ch_out[0] | chn_out[0]) ? 0 : 1;
    end
  endtask : win
  //////////////////////////////////////////////////
  task automatic t_regs();
    rd(`MPT_RELOAD);
    chk("reload rst", d, `MPT_RELOAD_RST);
    rd(`MPT_CTRL);
    chk("ctrl rst", d, 32'h0);
    wr(8'hFC, 32'hFFFF_FFFF);
    rd(8'hFC);
    chk("unmapped", d, 32'h0);
    wr(`MPT_RELOAD, 32'h1234_5678);
    rd(`MPT_RELOAD);
    chk("reload width", d, 32'h0000_5678);
  endtask : t_regs
  task automatic t_count();
    int cv[4] = '{1, 3, 5, 1};
    int pv[4] = '{0, 0, 0, 4};
    int ev[4] = '{3, 3, 2, 15};
    int n;
    wr(`MPT_RELOAD, 32'h2);
    for (int i = 0; i < 4; i++) begin
      wr(`MPT_PRESC, pv[i]);
      wr(`MPT_CTRL, cv[i]);
      span(n);
      span(n);
      chk("update gap", n, ev[i]);
    end
  endtask : t_count
  task automatic t_irq();
    wr(`MPT_CTRL, 32'h0);
    wr(`MPT_MASK, 32'h0);
    rd(`MPT_STATUS);
    chk("sts upd", d[0], 1'b1);
    chk("irq masked", o_irq, 1'b0);
    wr(`MPT_MASK, 32'h1);
    @(negedge i_clock);
    chk("irq set", o_irq, 1'b1);
    wr(`MPT_STATUS, 32'h1);
    @(negedge i_clock);
    chk("irq clr", o_irq, 1'b0);
    rd(`MPT_STATUS);
    chk("sts clr", d[0], 1'b0);
  endtask : t_irq
  task automatic t_dma();
    int k;
    k = 0;
    wr(`MPT_DMAEN, 32'h1);
    wr(`MPT_CTRL, 32'h1);
    while (o_dma_req !== 1'b1 && k < 50) begin
      @(negedge i_clock);
      k++;
    end
    wr(`MPT_CTRL, 32'h0);
    @(negedge i_clock);
    chk("dma held", o_dma_req, 1'b1);
    @(posedge i_clock);
    i_dma_ack <= 1'b1;
    @(posedge i_clock);
    i_dma_ack <= 1'b0;
    @(negedge i_clock);
    chk("dma ack", o_dma_req, 1'b0);
    wr(`MPT_DMAEN, 32'h0);
  endtask : t_dma
  task automatic t_pwm();
    int m, c, z;
    wr(`MPT_PRESC, 32'h0);
    wr(`MPT_RELOAD, 32'h9);
    wr(`MPT_COUNT, 32'h0);
    wr(`MPT_CHMODE, 32'h924);
    wr(`MPT_DEADT, 32'h3);
    wr(`MPT_CMP0, 32'h5);
    wr(`MPT_CTRL, 32'h81);
    win(m, c, z);
    chk("main hi", m, 32'h4);
    chk("comp hi", c, 32'h4);
    chk("dead", z, 32'hC);
    chk("oe", ch_oe[0], 1'b1);
    chk("no pair 3", chn_out[3], 1'b0);
    wr(`MPT_CMP0, 32'h0);
    win(m, c, z);
    chk("duty 0", m, 32'h0);
    chk("duty 0 comp", c, 32'h14);
    wr(`MPT_CMP0, 32'hA);
    win(m, c, z);
    chk("duty full", m, 32'h14);
    chk("overlap", pins.overlap, 32'h0);
  endtask : t_pwm
  task automatic t_freeze();
    wr(`MPT_CMP0, 32'h5);
    wr(`MPT_CTRL, 32'h91);
    @(posedge i_clock);
    i_dbg_halt <= 1'b1;
    rd(`MPT_COUNT);
    a = d;
    repeat (4) @(posedge i_clock);
    rd(`MPT_COUNT);
    chk("frozen", d, a);
    chk("out off", ch_out, 4'h0);
    chk("comp off", chn_out, 4'h0);
    chk("oe off", ch_oe, 4'h0);
    @(posedge i_clock);
    i_dbg_halt <= 1'b0;
  endtask : t_freeze
  task automatic t_link();
    wr(`MPT_RELOAD, 32'hFFFF);
    wr(`MPT_CTRL, 32'h201);
    rd(`MPT_COUNT);
    a = d;
    rd(`MPT_COUNT);
    chk("gate shut", d, a);
    @(posedge i_clock);
    i_link_trig <= 1'b1;
    rd(`MPT_COUNT);
    chk("gate open", d !== a, 1'b1);
    @(posedge i_clock);
    i_link_trig <= 1'b0;
  endtask : t_link
  task automatic t_onep();
    wr(`MPT_CTRL, 32'h0);
    wr(`MPT_RELOAD, 32'h2);
    wr(`MPT_COUNT, 32'h0);
    wr(`MPT_CTRL, 32'h9);
    repeat (10) @(posedge i_clock);
    rd(`MPT_CTRL);
    chk("onep stop", d[0], 1'b0);
    rd(`MPT_COUNT);
    a = d;
    rd(`MPT_COUNT);
    chk("onep hold", d, a);
  endtask : t_onep
  task automatic t_sense();
    wr(`MPT_RELOAD, 32'hFFFF);
    wr(`MPT_COUNT, 32'h0);
    wr(`MPT_CTRL, 32'h21);
    repeat (4) pins.step(1'b1);
    rd(`MPT_COUNT);
    chk("enc up", d, 32'h4);
    repeat (2) pins.step(1'b0);
    rd(`MPT_COUNT);
    chk("enc down", d, 32'h2);
    wr(`MPT_STATUS, 32'h3F);
    wr(`MPT_CTRL, 32'h41);
    pins.hall_flip();
    rd(`MPT_STATUS);
    chk("hall evt", d[5], 1'b1);
  endtask : t_sense
  task automatic t_cap();
    wr(`MPT_CTRL, 32'h0);
    wr(`MPT_CHMODE, 32'h1);
    wr(`MPT_COUNT, 32'h1234);
    wr(`MPT_STATUS, 32'h3F);
    pins.step(1'b1);
    rd(`MPT_CMP0);
    chk("capture", d, 32'h1234);
    rd(`MPT_STATUS);
    chk("capture evt", d[1], 1'b1);
  endtask : t_cap
  task automatic t_slave();
    wr(`MPT_CTRL, 32'h300);
    @(posedge i_clock);
    i_link_trig <= 1'b1;
    @(posedge i_clock);
    i_link_trig <= 1'b0;
    rd(`MPT_CTRL);
    chk("link start", d[0], 1'b1);
    wr(`MPT_CTRL, 32'h101);
    @(posedge i_clock);
    i_link_trig <= 1'b1;
    @(posedge i_clock);
    i_link_trig <= 1'b0;
    rd(`MPT_COUNT);
    chk("link reset", d, 32'h1);
  endtask : t_slave
  task automatic t_rst();
    @(posedge i_clock);
    i_nrst <= 1'b0;
    repeat (2) @(posedge i_clock);
    i_nrst <= 1'b1;
    rd(`MPT_CTRL);
    chk("ctrl rst 2", d, 32'h0);
    rd(`MPT_RELOAD);
    chk("reload rst 2", d, `MPT_RELOAD_RST);
    chk("irq rst", o_irq, 1'b0);
    chk("trgo rst", o_link_trgo, 1'b0);
  endtask : t_rst
  //////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge i_clock);
    i_nrst <= 1'b1;
    t_regs();
    t_count();
    t_irq();
    t_dma();
    t_pwm();
    t_freeze();
    t_link();
    t_onep();
    t_sense();
    t_cap();
    t_slave();
    t_rst();
    wrap_up();
  end
  initial begin
    repeat (20000) @(posedge i_clock);
    fails++;
    wrap_up();
  end
endmodule : tb
`default_nettype wire
